// file: design/imm_alu_consts.svh
`ifndef IMM_ALU_CONSTS_SVH
`define IMM_ALU_CONSTS_SVH
// ==========================================
// Opcodes
`define PFX_REG_IMM     8'h74
`define PFX_SPECIAL_IMM 8'h64
`define PFX_WIDE_REG    8'h70
`define OP_SBI_ACC      8'h76
`define OP_ANI_WORK     8'h05
`define OP_ORI_WORK     8'h15
// Operation field codes
`define FN_SUB          4'hc
`define FN_SBB          4'he
`define FN_SUB_NB       4'h6
`define FN_GT           4'h5
`define FN_NE           4'hd
`define FN_EQ           4'hf
`define FN_TEST_ANY     4'h9
`define FN_TEST_CLR     4'hb
// Wide upper bits
`define WD_ADD          6'h31
`define WD_SUB_NB       6'h2d
`define WD_AND          6'h23
`define WD_OR           6'h27
`define WD_BYTE_ADD     6'h10
`define WD_BYTE_SUB     6'h18
// State counts
`define ST_ACC_IMM      8'd7
`define ST_REG_IMM      8'd11
`define ST_SPECIAL      8'd20
`define ST_SPECIAL_CMP  8'd14
`define ST_WORK_ACC     8'd14
`define ST_WORK_RMW     8'd19
`define ST_WORK_CMP     8'd13
`define ST_WIDE         8'd11
`define ST_SKIP_1B      8'd4
`define ST_SKIP_2B      8'd8
`endif

// file: design/imm_alu_pkg.sv
package imm_alu_pkg;
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_BYTE2 = 5'b00010,
    S_BYTE3 = 5'b00100,
    S_EXEC  = 5'b01000,
    S_SKIP  = 5'b10000
  } dec_state_t;
  typedef struct packed {
    logic [7:0]  acc;
    logic [15:0] wide_accumulator;
    logic [7:0]  reg_val;
    logic [7:0]  special_val;
    logic [15:0] pair_val;
    logic [7:0]  mem_rdata;
    logic [7:0]  page;
    logic        carry_flag;
  } operands_t;
  typedef struct packed {
    logic        acc_we;
    logic [7:0]  acc;
    logic        reg_we;
    logic        special_we;
    logic [7:0]  byte_res;
    logic        wide_we;
    logic [15:0] wide_res;
    logic        mem_we;
    logic [7:0]  mem_wdata;
    logic        carry_we;
    logic        carry_flag;
  } results_t;
endpackage

// file: design/imm_alu_decoder.sv
`timescale 1ns/1ns
`include "imm_alu_consts.svh"
// Notes on behaviour
// RQ1: Byte 01110110 plus data subtracts data and carry from the accumulator in 7 states.
// RQ2: Prefix 01110100, a 5-bit operation and 3-bit register byte, then data, runs in 11 states.
// RQ3: Prefix 01100100 with S3, 4-bit operation, S2..S0, then data, modifies a special register in 20 states.
// RQ4: Special-register compare and test take 14 states and only evaluate the skip.
// RQ5: Special field 1100 subtracts, 1110 subtracts with borrow, 0110 subtracts skipping on no borrow.
// RQ6: Compare 0101 skips on no borrow of operand-byte-1, 1101 on non-zero, 1111 on zero.
// RQ7: Test 1001 skips when the AND is non-zero, 1011 when it is zero, nothing stored.
// RQ8: Working accumulator operations are prefix, operation, offset, address page:offset, 14 states.
// RQ9: Opcodes 00000101 and 00010101 with offset then data AND or OR into the working byte.
// RQ10: Working compare and test take 13 states and leave memory unchanged.
// RQ11: Prefix 01110000 with a 2-bit register select adds or subtracts a byte register to the wide accumulator.
// RQ12: Prefix 01110100, upper bits 110001, low two bits a pair, adds the pair in 11 states.
// RQ13: Upper bits 101101 store the wide difference and skip on no borrow.
// RQ14: Upper bits 100011 and 100111 AND and OR the pair into the wide accumulator.
// RQ15: A taken skip passes over the next instruction as 4 idle states for one byte, 8 for two.
// RQ16: A skip affects only the single next instruction.
// RQ17: Register and special-register selects go out raw for an external mapping table.
module imm_alu_decoder
  import imm_alu_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             byte_valid,
  input  wire logic [7:0]       byte_in,
  input  wire logic             next_two_byte,
  input  wire operands_t        ops,
  output logic                  byte_ready,
  output logic                  busy,
  output logic [2:0]            reg_select,
  output logic [3:0]            special_register_select,
  output logic [1:0]            pair_select,
  output logic [15:0]           mem_addr,
  output logic                  mem_rd,
  output results_t              res,
  output logic                  skipping
);
  // ==========================================
  // Decode
  dec_state_t       state_reg, state_next;
  logic [7:0]       op1_reg, op2_reg, data_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             skip_pend_reg;
  logic             fmt_reg, fmt_spc, fmt_wide, fmt_acc, fmt_work_rmw;
  logic [3:0]       spc_fn;
  logic [4:0]       reg_fn;
  logic [5:0]       wide_fn;
  logic             is_work_acc, is_cmp_spc, is_cmp_reg, fmt_work_imm, fmt_work_cmp;
  logic [3:0]       cmp_fn;
  logic             three_bytes;

  // Working-area immediate opcodes all end in 0101 with the top bit clear
  function automatic logic is_work_opc(input logic [7:0] b);
    return b[3:0] == 4'h5 && !b[7];
  endfunction

  assign fmt_reg      = op1_reg == `PFX_REG_IMM;
  assign fmt_spc      = op1_reg == `PFX_SPECIAL_IMM;
  assign fmt_wide     = op1_reg == `PFX_WIDE_REG;
  assign fmt_acc      = op1_reg == `OP_SBI_ACC;                                        // [RQ1]
  assign fmt_work_rmw = op1_reg == `OP_ANI_WORK || op1_reg == `OP_ORI_WORK;            // [RQ9]
  assign fmt_work_imm = is_work_opc(op1_reg);
  assign fmt_work_cmp = fmt_work_imm && !fmt_work_rmw;                                 // [RQ10]
  assign reg_fn       = op2_reg[7:3];                                                  // [RQ2]
  assign spc_fn       = op2_reg[6:3];                                                  // [RQ3]
  assign wide_fn      = op2_reg[7:2];
  assign is_work_acc  = fmt_reg && op2_reg[7] && op2_reg[2:0] == 3'b000;
  // Working compares carry their code in the opcode's upper bits, same coding as the register form
  assign cmp_fn       = fmt_spc ? spc_fn : fmt_work_cmp ? {op1_reg[6:4], 1'b1} : reg_fn[3:0];
  assign is_cmp_spc   = fmt_spc && spc_fn[0] && spc_fn != 4'h3 && spc_fn != 4'h1;     // [RQ4]
  assign is_cmp_reg   = fmt_reg && !op2_reg[7] && reg_fn[0] && reg_fn[3:0] != 4'h1 && reg_fn[3:0] != 4'h3;
  assign three_bytes  = (fmt_reg && !op2_reg[7]) || fmt_spc || fmt_work_imm ||
                        (fmt_reg && op2_reg[7] && op2_reg[2:0] == 3'b000);
  assign reg_select   = op2_reg[2:0];                                                  // [RQ17]
  assign special_register_select = {op2_reg[7], op2_reg[2:0]};                         // [RQ17]
  assign pair_select  = op2_reg[1:0];
  assign mem_addr     = {ops.page, fmt_work_imm ? op2_reg : data_reg};                 // [RQ8]
  assign mem_rd       = state_reg == S_EXEC;
  // A pending skip refuses bytes, otherwise a byte would look taken while being dropped
  assign byte_ready   = (state_reg == S_IDLE && !skip_pend_reg) || state_reg == S_BYTE2 || state_reg == S_BYTE3;
  assign busy         = state_reg == S_EXEC || state_reg == S_SKIP || skip_pend_reg;
  assign skipping     = state_reg == S_SKIP;

  // ==========================================
  // Execute
  logic [7:0]  opnd, imm;
  logic [8:0]  diff, diff_gt, sum;
  logic [7:0]  land;
  logic        skip_now;
  logic [16:0] wsum, wdiff;
  logic [15:0] wopnd;
  logic [CNT_W-1:0] exec_states;
  logic        wide_byte, is_cmp;
  results_t    r;

  assign wide_byte = fmt_wide && (wide_fn == `WD_BYTE_ADD || wide_fn == `WD_BYTE_SUB);  // [RQ11]
  assign opnd  = fmt_acc ? ops.acc : fmt_spc ? ops.special_val :
                 (fmt_work_imm || is_work_acc) ? ops.mem_rdata : ops.reg_val;
  assign imm   = is_work_acc ? ops.mem_rdata : data_reg;
  // Add-with-carry (code 1010) folds the carry into the sum; SBB and the accumulator subtract fold it into the difference
  assign sum   = {1'b0, opnd} + {1'b0, imm} + {8'h00, cmp_fn == 4'ha && ops.carry_flag};
  assign diff  = {1'b0, opnd} - {1'b0, imm} - {8'h00, (fmt_acc || cmp_fn == `FN_SBB) && ops.carry_flag};
  assign diff_gt = {1'b0, opnd} - {1'b0, imm} - 9'h001;                                // [RQ6]
  assign land  = opnd & imm;                                                           // [RQ7]
  assign wopnd = wide_byte ? {8'h00, ops.reg_val} : ops.pair_val;
  assign wsum  = {1'b0, ops.wide_accumulator} + {1'b0, wopnd};
  assign wdiff = {1'b0, ops.wide_accumulator} - {1'b0, wopnd};
  assign is_cmp = is_cmp_spc || is_cmp_reg || fmt_work_cmp;

  always_comb begin
    r = '0;
    skip_now = 1'b0;
    exec_states = CNT_W'(`ST_REG_IMM);
    if (fmt_acc) begin
      r.acc_we = 1'b1;                                                                 // [RQ1]
      r.acc = diff[7:0];
      r.carry_we = 1'b1;
      r.carry_flag = diff[8];
      exec_states = CNT_W'(`ST_ACC_IMM);
    end else if (fmt_work_rmw) begin
      r.mem_we = 1'b1;                                                                 // [RQ9]
      r.mem_wdata = op1_reg == `OP_ANI_WORK ? (ops.mem_rdata & data_reg) : (ops.mem_rdata | data_reg);
      exec_states = CNT_W'(`ST_WORK_RMW);
    end else if (fmt_wide) begin
      r.wide_we = 1'b1;                                                                // [RQ11]
      r.wide_res = wide_fn == `WD_BYTE_SUB ? wdiff[15:0] : wsum[15:0];
      exec_states = CNT_W'(`ST_WIDE);
    end else if (fmt_reg && op2_reg[7] && !is_work_acc) begin
      exec_states = CNT_W'(`ST_WIDE);                                                  // [RQ12]
      r.wide_we = 1'b1;
      case (wide_fn)
        `WD_ADD: r.wide_res = wsum[15:0];                                              // [RQ12]
        `WD_SUB_NB: begin
          r.wide_res = wdiff[15:0];                                                    // [RQ13]
          skip_now = !wdiff[16];
        end
        `WD_AND: r.wide_res = ops.wide_accumulator & ops.pair_val;                     // [RQ14]
        `WD_OR: r.wide_res = ops.wide_accumulator | ops.pair_val;                      // [RQ14]
        default: r.wide_we = 1'b0;
      endcase
    end else if (is_work_acc) begin
      exec_states = CNT_W'(`ST_WORK_ACC);                                              // [RQ8]
      r.acc_we = 1'b1;
      r.acc = ops.acc + ops.mem_rdata;
    end else begin
      // Register and special forms share the same ALU; the write target and the state count differ
      if (fmt_spc) exec_states = is_cmp ? CNT_W'(`ST_SPECIAL_CMP) : CNT_W'(`ST_SPECIAL); // [RQ3] [RQ4]
      if (fmt_work_cmp) exec_states = CNT_W'(`ST_WORK_CMP);                            // [RQ10]
      case (cmp_fn)
        `FN_GT: skip_now = !diff_gt[8];                                                // [RQ6]
        `FN_NE: skip_now = diff[7:0] != 8'h00;                                         // [RQ6]
        `FN_EQ: skip_now = diff[7:0] == 8'h00;                                         // [RQ6]
        `FN_TEST_ANY: skip_now = land != 8'h00;                                        // [RQ7]
        `FN_TEST_CLR: skip_now = land == 8'h00;                                        // [RQ7]
        `FN_SUB_NB: skip_now = !diff[8];                                               // [RQ5]
        default: skip_now = 1'b0;
      endcase
      if (!is_cmp) begin
        r.reg_we = fmt_reg;                                                            // [RQ2]
        r.special_we = fmt_spc;                                                        // [RQ5]
        r.byte_res = (cmp_fn == `FN_SUB || cmp_fn == `FN_SBB || cmp_fn == `FN_SUB_NB) ? diff[7:0] :
                     cmp_fn == 4'h1 ? land : cmp_fn == 4'h3 ? (opnd | imm) :
                     cmp_fn == 4'h2 ? (opnd ^ imm) : sum[7:0];
      end
    end
  end

  // ==========================================
  // Sequencer
  logic cnt_done;
  assign cnt_done = cnt_reg == CNT_W'(1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:  if (byte_valid && !skip_pend_reg) state_next = (byte_in == `OP_SBI_ACC || is_work_opc(byte_in) ||
                   byte_in == `PFX_REG_IMM || byte_in == `PFX_SPECIAL_IMM ||
                   byte_in == `PFX_WIDE_REG) ? S_BYTE2 : S_IDLE;
               else if (skip_pend_reg) state_next = S_SKIP;                            // [RQ16]
      S_BYTE2: if (byte_valid) state_next = (fmt_wide || (fmt_reg && byte_in[7] && byte_in[2:0] != 3'b000) ||
                   fmt_acc) ? S_EXEC : S_BYTE3;
      S_BYTE3: if (byte_valid) state_next = S_EXEC;
      S_EXEC:  if (cnt_done) state_next = S_IDLE;
      S_SKIP:  if (cnt_done) state_next = S_IDLE;                                      // [RQ15]
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      op1_reg <= 8'h00;
      op2_reg <= 8'h00;
      data_reg <= 8'h00;
      cnt_reg <= '0;
      skip_pend_reg <= 1'b0;
      res <= '0;
    end else begin
      state_reg <= state_next;
      res <= '0;
      if (state_reg == S_IDLE && byte_valid && !skip_pend_reg) op1_reg <= byte_in;
      if (state_reg == S_BYTE2 && byte_valid) begin
        op2_reg <= byte_in;
        data_reg <= byte_in;
        if (state_next == S_EXEC) cnt_reg <= '0;
      end
      if (state_reg == S_BYTE3 && byte_valid) data_reg <= byte_in;
      if (state_reg != S_EXEC && state_next == S_EXEC) cnt_reg <= '0;
      if (state_reg == S_EXEC) begin
        // Fetch cycles count toward the state total, so execute only runs the remainder
        if (cnt_reg == '0) cnt_reg <= exec_states - CNT_W'(three_bytes ? 4 : 3);
        else cnt_reg <= cnt_reg - CNT_W'(1);
        if (cnt_done) begin
          res <= r;
          skip_pend_reg <= skip_now;
        end
      end
      if (state_reg == S_IDLE && skip_pend_reg) begin
        cnt_reg <= CNT_W'(next_two_byte ? `ST_SKIP_2B : `ST_SKIP_1B);                  // [RQ15]
        skip_pend_reg <= 1'b0;                                                         // [RQ16]
      end else if (state_reg == S_SKIP && !cnt_done) cnt_reg <= cnt_reg - CNT_W'(1);
    end
  end

  // ==========================================
  // Checks
  skip_len_a: assert property (@(posedge clk) disable iff (rst)  // [RQ15]
    state_reg == S_IDLE && skip_pend_reg && !next_two_byte |=> skipping [*4] ##1 !skipping)
    else $error("one-byte skip not four states");
  skip_once_a: assert property (@(posedge clk) disable iff (rst)  // [RQ16]
    $fell(skipping) |-> !skip_pend_reg)
    else $error("skip repeated");
  eq_skip_a: assert property (@(posedge clk) disable iff (rst)  // [RQ6]
    state_reg == S_EXEC && cnt_done && !fmt_wide && cmp_fn == `FN_EQ && fmt_spc && diff[7:0] == 8'h00
    |=> skip_pend_reg) else $error("equal skip missed");
  test_store_a: assert property (@(posedge clk) disable iff (rst)  // [RQ7] [RQ10]
    state_reg == S_EXEC && cnt_done && is_cmp |=> !res.reg_we && !res.special_we && !res.mem_we)
    else $error("compare stored result");
  acc_sub_a: assert property (@(posedge clk) disable iff (rst)  // [RQ1]
    state_reg == S_EXEC && cnt_done && fmt_acc |=> res.acc_we && res.acc == $past(diff[7:0]))
    else $error("accumulator subtract wrong");
  rmw_write_a: assert property (@(posedge clk) disable iff (rst)  // [RQ9]
    $rose(res.mem_we) |-> $past(fmt_work_rmw))
    else $error("unexpected working write");
  wide_sub_a: assert property (@(posedge clk) disable iff (rst)  // [RQ13]
    state_reg == S_EXEC && cnt_done && fmt_reg && wide_fn == `WD_SUB_NB && op2_reg[7]
    |=> skip_pend_reg == !$past(wdiff[16])) else $error("wide skip wrong");
  addr_form_a: assert property (@(posedge clk) disable iff (rst)  // [RQ8]
    mem_rd |-> mem_addr[15:8] == ops.page) else $error("page not high byte");
  skip_cov_c: cover property (@(posedge clk) $rose(skipping));
  rmw_cov_c: cover property (@(posedge clk) res.mem_we);
  wide_cov_c: cover property (@(posedge clk) res.wide_we);
endmodule

// file: test/immediate_and_wide_alu_ops_test.sv
`timescale 1ns/1ns
`include "imm_alu_consts.svh"
// ==========================================
// Bench for the immediate and wide decoder
module immediate_and_wide_alu_ops_test
  import imm_alu_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        byte_valid = 1'b0;
  logic [7:0]  byte_in = 8'h00;
  logic        next_two_byte = 1'b0;
  operands_t   ops = '0;
  logic        byte_ready, busy, skipping, mem_rd;
  logic [2:0]  reg_select;
  logic [3:0]  special_register_select;
  logic [1:0]  pair_select;
  logic [15:0] mem_addr;
  results_t    res, cap;
  integer      n_mismatch = 0;
  integer      n_compared = 0;
  integer      seed = 32'hde3af380;
  int          nskip, nexec, k;
  logic [95:0] r96;
  logic [7:0]  data, off;
  logic [3:0]  fn, s;
  logic [5:0]  w;
  logic [9:0]  e;
  logic [17:0] ew;
  logic [3:0]  fns [8] = '{`FN_SUB, `FN_SBB, `FN_SUB_NB, `FN_GT, `FN_NE, `FN_EQ, `FN_TEST_ANY, `FN_TEST_CLR};
  logic [5:0]  wds [4] = '{`WD_ADD, `WD_SUB_NB, `WD_AND, `WD_OR};

  imm_alu_decoder u_dut (.clk(clk), .rst(rst), .byte_valid(byte_valid), .byte_in(byte_in),
    .next_two_byte(next_two_byte), .ops(ops), .byte_ready(byte_ready), .busy(busy),
    .reg_select(reg_select), .special_register_select(special_register_select),
    .pair_select(pair_select), .mem_addr(mem_addr), .mem_rd(mem_rd), .res(res), .skipping(skipping));

  always #10 clk = ~clk;

  // ==========================================
  // Checking and closing
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================
  // Byte handshake; a stalled handshake ends the run
  task automatic send(input logic [7:0] b);
    int  t;
    logic ok;
    byte_valid = 1'b1;
    byte_in = b;
    ok = 1'b0;
    for (t = 0; t < 50 && !ok; t++) begin
      @(negedge clk);
      ok = byte_ready;
      @(posedge clk);
      #1;
    end
    if (!ok) begin
      n_mismatch++;
      stop_test;
    end
  endtask

  // Idle for three cycles in a row marks the end, since skip may start one idle cycle late
  task automatic run(input int n, input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    int t, idle;
    send(b0);
    if (n > 1) send(b1);
    if (n > 2) send(b2);
    byte_valid = 1'b0;
    cap = '0;
    nskip = 0;
    nexec = 0;
    idle = 0;
    for (t = 0; t < 60 && idle < 3; t++) begin
      @(negedge clk);
      if (res.acc_we | res.reg_we | res.special_we | res.wide_we | res.mem_we) cap = res;
      nskip += int'(skipping);
      nexec += int'(mem_rd);
      idle = busy ? 0 : idle + 1;
    end
    if (idle < 3) begin
      n_mismatch++;
      stop_test;
    end
    // Hand back just after a rising edge so the next request starts off the sampling edge
    @(posedge clk);
    #1;
  endtask

  // ==========================================
  // Expected values: {skip, write, result}
  function automatic logic [9:0] fn_eval(input logic [3:0] f, input logic [7:0] a, input logic [7:0] b,
                                         input logic cy);
    case (f)
      `FN_SUB:      return {2'b01, 8'(a - b)};
      `FN_SBB:      return {2'b01, 8'(a - b - {7'h00, cy})};
      `FN_SUB_NB:   return {a >= b, 1'b1, 8'(a - b)};
      `FN_GT:       return {a > b, 9'h000};
      `FN_NE:       return {a != b, 9'h000};
      `FN_EQ:       return {a == b, 9'h000};
      `FN_TEST_ANY: return {(a & b) != 8'h00, 9'h000};
      default:      return {(a & b) == 8'h00, 9'h000};
    endcase
  endfunction

  function automatic logic [17:0] wd_eval(input logic [5:0] u, input logic [15:0] a, input logic [15:0] b);
    case (u)
      `WD_ADD:    return {2'b01, 16'(a + b)};
      `WD_SUB_NB: return {a >= b, 1'b1, 16'(a - b)};
      `WD_AND:    return {2'b01, a & b};
      default:    return {2'b01, a | b};
    endcase
  endfunction

  function automatic int skip_len(input logic sk);
    return sk ? (next_two_byte ? 8 : 4) : 0;
  endfunction

  // ==========================================
  // Main sequence; the last eight rounds force equal operands
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    check(busy, 0);
    check(32'(res !== '0), 0);
    for (k = 0; k < 32; k++) begin
      r96 = {$random(seed), $random(seed), $random(seed)};
      ops = r96[72:0];
      data = 8'($random(seed));
      off = 8'($random(seed));
      s = 4'($random(seed));
      next_two_byte = 1'($random(seed));
      if (k >= 24) begin
        ops.special_val = data;
        ops.reg_val = data;
        ops.mem_rdata = data;
        ops.pair_val = ops.wide_accumulator;
      end
      fn = fns[k % 8];
      run(3, `PFX_SPECIAL_IMM, {s[3], fn, s[2:0]}, data);
      e = fn_eval(fn, ops.special_val, data, ops.carry_flag);
      check(cap.special_we, e[8]);
      if (e[8]) check(cap.byte_res, e[7:0]);
      check(nskip, skip_len(e[9]));
      check(nexec, (e[8] ? `ST_SPECIAL : `ST_SPECIAL_CMP) - 3);
      check(special_register_select, s);
      run(3, `PFX_REG_IMM, {1'b0, fn, s[2:0]}, data);
      e = fn_eval(fn, ops.reg_val, data, ops.carry_flag);
      check(cap.reg_we, e[8]);
      if (e[8]) check(cap.byte_res, e[7:0]);
      check(nskip, skip_len(e[9]));
      check(reg_select, s[2:0]);
      check(nexec, `ST_REG_IMM - 3);
      run(2, `OP_SBI_ACC, data, 8'h00);
      check(cap.acc_we, 1);
      check(cap.acc, 8'(ops.acc - data - {7'h00, ops.carry_flag}));
      check(nexec, `ST_ACC_IMM - 2);
      run(3, k[0] ? `OP_ORI_WORK : `OP_ANI_WORK, off, data);
      check(cap.mem_we, 1);
      check(cap.mem_wdata, k[0] ? (ops.mem_rdata | data) : (ops.mem_rdata & data));
      check(mem_addr, {ops.page, off});
      check(nexec, `ST_WORK_RMW - 3);
      run(3, k[0] ? 8'h75 : 8'h65, off, data);
      check(cap.mem_we, 0);
      check(nskip, skip_len((ops.mem_rdata == data) == k[0]));
      check(nexec, `ST_WORK_CMP - 3);
      w = wds[k % 4];
      run(2, `PFX_REG_IMM, {w, s[1:0]}, 8'h00);
      ew = wd_eval(w, ops.wide_accumulator, ops.pair_val);
      check(cap.wide_we, 1);
      check(cap.wide_res, ew[15:0]);
      check(nskip, skip_len(ew[17]));
      check(pair_select, s[1:0]);
      check(nexec, `ST_WIDE - 2);
      run(2, `PFX_WIDE_REG, {k[0] ? `WD_BYTE_SUB : `WD_BYTE_ADD, s[1:0]}, 8'h00);
      ew[15:0] = 16'(ops.wide_accumulator + {8'h00, ops.reg_val});
      if (k[0]) ew[15:0] = 16'(ops.wide_accumulator - {8'h00, ops.reg_val});
      check(cap.wide_we, 1);
      check(cap.wide_res, ew[15:0]);
      check(reg_select[1:0], s[1:0]);
      check(nexec, `ST_WIDE - 2);
      if (k % 8 == 7) $display("round %0d done, compared %0d", k, n_compared);
    end
    stop_test;
  end
endmodule
